/* File: verilog/scfg_pkg.sv */
// Purpose: shared constants of the serial configuration write port
// Assumes: register addresses are the 3-bit frame address
// Notes: field positions of the control and settling words are fixed here
package scfg_pkg;
	localparam int SCFG_ADDR_W = 3;
	localparam int SCFG_DATA_W = 16;
	localparam int SCFG_FRAME_W = SCFG_ADDR_W + SCFG_DATA_W;
	localparam logic [4:0] SCFG_FRAME_LOW_CYCLES = 5'h14;
	localparam logic [4:0] SCFG_SHIFT_CYCLES = 5'h13;

	localparam logic [2:0] SCFG_ADDR_GENERAL_CONTROL = 3'h0;
	localparam logic [2:0] SCFG_ADDR_ANALOG_GAIN_ADJUST = 3'h1;
	localparam logic [2:0] SCFG_ADDR_OFFSET_ADJUST = 3'h2;
	localparam logic [2:0] SCFG_ADDR_INTERNAL_SETTLING_ADJUST = 3'h4;
	localparam logic [2:0] SCFG_ADDR_TEST_PATTERN = 3'h5;

	localparam int SCFG_GAIN_W = 8;
	localparam int SCFG_OFFSET_W = 8;
	localparam int SCFG_PATTERN_W = 12;

	localparam logic [15:0] SCFG_RST_GENERAL_CONTROL = 16'h0040;
	localparam logic [7:0] SCFG_RST_ANALOG_GAIN_ADJUST = 8'h80;
	localparam logic [7:0] SCFG_RST_OFFSET_ADJUST = 8'h80;
	localparam logic [15:0] SCFG_RST_INTERNAL_SETTLING_ADJUST = 16'h1410;
	localparam logic [11:0] SCFG_RST_TEST_PATTERN = 12'h000;

	localparam int SCFG_CTRL_STANDBY_BIT = 0;
	localparam int SCFG_CTRL_TEST_BIT = 7;
	localparam int SCFG_CTRL_TRANSPARENT_BIT = 15;

	localparam int SCFG_SET_DC_LSB = 0;
	localparam int SCFG_SET_DC_W = 5;
	localparam int SCFG_SET_TRIM_LSB = 8;
	localparam int SCFG_SET_TRIM_W = 2;
	localparam int SCFG_SET_DUTY_LSB = 13;
	localparam int SCFG_SET_DUTY_W = 3;

	localparam int SCFG_SYNC_W = 4;
	localparam int SCFG_SYNC_SMODE = 3;
	localparam int SCFG_SYNC_SCLK = 2;
	localparam int SCFG_SYNC_SLDN = 1;
	localparam int SCFG_SYNC_SDATA = 0;
endpackage : scfg_pkg

/* File: verilog/scfg_sync.sv */
// Purpose: three-stage synchroniser for slow pins
// Assumes: pins change far slower than sys_clk
// Notes: output moves only once stages two and three agree
`timescale 1ns/1ps
module scfg_sync #(
	parameter int W = 1
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] level
);
	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;
	logic [W-1:0] next_level;

	always_comb begin
		for (int i = 0; i < W; i++) begin
			next_level[i] = (stage2[i] == stage3[i]) ? stage3[i] : level[i];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
			level <= '0;
		end else begin
			stage1 <= pin_in;
			stage2 <= stage1;
			stage3 <= stage2;
			level <= next_level;
		end
	end
endmodule : scfg_sync

/* File: verilog/scfg_reg.sv */
// Purpose: one configuration register slot
// Assumes: clear and write come from the same clock
// Notes: clear holds the default and beats a write
`timescale 1ns/1ps
module scfg_reg #(
	parameter int W = 16,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic clear,
	input wire logic we,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] next_q;

	always_comb begin
		next_q = q;
		if (clear) begin
			next_q = RST;
		end else if (we) begin
			next_q = d;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			q <= RST;
		end else begin
			q <= next_q;
		end
	end
endmodule : scfg_reg

/* File: verilog/scfg_port.sv */
// Purpose: write-only three-wire configuration port with its registers
// Assumes: sclk, sldn, sdata and smode are asynchronous pins, sclk much slower
//   than sys_clk (at least eight sys_clk periods per sclk period)
// Notes: the serial clock is sampled as a level, its rising edges found here
//
// Functional notes
// - writes accepted only while smode high
// - smode low holds all registers at defaults
// - write only, eight addresses, sixteen bits
// - frame: 3 address then 16 data, MSB first
// - sldn and sdata sampled on sclk rises only
// - write starts at first low sldn sample
// - first three low cycles shift address MSB first
// - next sixteen low cycles shift data MSB first
// - twentieth low cycle loads addressed register
// - early high sldn abandons write, no change
// - further low cycles ignored until sldn high
// - one high cycle suffices before next write
// - bits beyond register width are discarded
// - timing reset leaves configuration registers alone
// - standby bit one enters standby, keeps registers
// - transparent and test bits enable on one
// - gain code is eight bits, upper unused
// - gain resets to code 0x80
// - test enable is control bit seven
// - test mode drives pattern and its complement
`timescale 1ns/1ps
module scfg_port
	import scfg_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic smode,
	input wire logic sclk,
	input wire logic sldn,
	input wire logic sdata,
	input wire logic [SCFG_PATTERN_W-1:0] conv_data,
	output logic standby_field,
	output logic track_hold_transparent,
	output logic test_enable,
	output logic [SCFG_GAIN_W-1:0] gain_code,
	output logic [SCFG_OFFSET_W-1:0] offset_code,
	output logic [SCFG_SET_DC_W-1:0] dc_trim,
	output logic [SCFG_SET_TRIM_W-1:0] settling_trim,
	output logic [SCFG_SET_DUTY_W-1:0] duty_cycle,
	output logic [SCFG_PATTERN_W-1:0] test_pattern_word,
	output logic [SCFG_PATTERN_W-1:0] data_out,
	output logic [SCFG_PATTERN_W-1:0] data_out_n,
	output logic port_enabled,
	output logic write_done
);
	typedef enum logic [1:0] {
		SCFG_WAIT_HIGH = 2'b00,
		SCFG_ARMED = 2'b01,
		SCFG_SHIFT = 2'b10,
		SCFG_HOLD = 2'b11
	} scfg_state_t;

	// pin synchronisation
	logic [SCFG_SYNC_W-1:0] pins_level;
	logic smode_s;
	logic sclk_s;
	logic sldn_s;
	logic sdata_s;
	logic sclk_prev;
	logic next_sclk_prev;
	logic sldn_prev;
	logic next_sldn_prev;
	logic sdata_prev;
	logic next_sdata_prev;
	logic sclk_rise;

	// all four pins share one latency, so sclk stays aligned with its data
	scfg_sync #(
		.W(SCFG_SYNC_W)
	) u_sync (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.pin_in({smode, sclk, sldn, sdata}),
		.level(pins_level)
	);

	assign smode_s = pins_level[SCFG_SYNC_SMODE];
	assign sclk_s = pins_level[SCFG_SYNC_SCLK];
	assign sldn_s = pins_level[SCFG_SYNC_SLDN];
	assign sdata_s = pins_level[SCFG_SYNC_SDATA];

	// the line values one cycle before the clock rise is seen are used, so a
	// data change just after the edge cannot leak into the sample
	always_comb begin
		next_sclk_prev = sclk_s;
		next_sldn_prev = sldn_s;
		next_sdata_prev = sdata_s;
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			sclk_prev <= 1'b0;
			sldn_prev <= 1'b1;
			sdata_prev <= 1'b0;
		end else begin
			sclk_prev <= next_sclk_prev;
			sldn_prev <= next_sldn_prev;
			sdata_prev <= next_sdata_prev;
		end
	end

	assign sclk_rise = sclk_s & ~sclk_prev;

	// serial frame state
	scfg_state_t state;
	scfg_state_t next_state;
	logic [4:0] low_count;
	logic [4:0] next_low_count;
	logic [SCFG_FRAME_W-1:0] shift_reg;
	logic [SCFG_FRAME_W-1:0] next_shift_reg;
	logic frame_load;
	logic [4:0] count_plus;

	// five bits reach the twentieth low rise; the count rests there in hold
	assign count_plus = low_count + 5'h01;

	always_comb begin
		next_state = state;
		next_low_count = low_count;
		next_shift_reg = shift_reg;
		frame_load = 1'b0;
		if (!smode_s) begin
			next_state = SCFG_WAIT_HIGH;
			next_low_count = 5'h00;
			next_shift_reg = '0;
		end else if (sclk_rise) begin
			unique case (state)
				SCFG_WAIT_HIGH: begin
					if (sldn_prev) begin
						next_state = SCFG_ARMED;
					end
				end
				SCFG_ARMED: begin
					if (!sldn_prev) begin
						next_state = SCFG_SHIFT;
						next_low_count = 5'h01;
						next_shift_reg = {shift_reg[SCFG_FRAME_W-2:0], sdata_prev};
					end
				end
				SCFG_SHIFT: begin
					if (sldn_prev) begin
						// the aborting high rise also arms, so a new frame may follow
						next_state = SCFG_ARMED;
						next_low_count = 5'h00;
					end else if (count_plus == SCFG_FRAME_LOW_CYCLES) begin
						// the twentieth low rise carries no bit; it only loads
						next_state = SCFG_HOLD;
						next_low_count = count_plus;
						frame_load = 1'b1;
					end else begin
						next_low_count = count_plus;
						if (count_plus <= SCFG_SHIFT_CYCLES) begin
							// address bits first, then data, each MSB first
							next_shift_reg = {shift_reg[SCFG_FRAME_W-2:0], sdata_prev};
						end
					end
				end
				SCFG_HOLD: begin
					// sldn still low: further rises neither shift nor load
					if (sldn_prev) begin
						next_state = SCFG_ARMED;
						next_low_count = 5'h00;
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			state <= SCFG_WAIT_HIGH;
			low_count <= 5'h00;
			shift_reg <= '0;
		end else begin
			state <= next_state;
			low_count <= next_low_count;
			shift_reg <= next_shift_reg;
		end
	end

	// address decode of a completed frame
	logic [SCFG_ADDR_W-1:0] frame_addr;
	logic [SCFG_DATA_W-1:0] frame_data;
	logic regs_clear;
	logic we_control;
	logic we_gain;
	logic we_offset;
	logic we_settling;
	logic we_pattern;

	assign frame_addr = shift_reg[SCFG_FRAME_W-1:SCFG_DATA_W];
	assign frame_data = shift_reg[SCFG_DATA_W-1:0];
	// smode low clears; nrst is the only other path to the defaults
	assign regs_clear = ~smode_s;

	// no readback path exists; addresses 3, 6 and 7 decode to nothing
	always_comb begin
		we_control = 1'b0;
		we_gain = 1'b0;
		we_offset = 1'b0;
		we_settling = 1'b0;
		we_pattern = 1'b0;
		if (frame_load) begin
			unique case (frame_addr)
				SCFG_ADDR_GENERAL_CONTROL: we_control = 1'b1;
				SCFG_ADDR_ANALOG_GAIN_ADJUST: we_gain = 1'b1;
				SCFG_ADDR_OFFSET_ADJUST: we_offset = 1'b1;
				SCFG_ADDR_INTERNAL_SETTLING_ADJUST: we_settling = 1'b1;
				SCFG_ADDR_TEST_PATTERN: we_pattern = 1'b1;
				default: we_control = 1'b0;
			endcase
		end
	end

	// configuration registers
	logic [SCFG_DATA_W-1:0] general_control;
	logic [SCFG_GAIN_W-1:0] analog_gain_adjust;
	logic [SCFG_OFFSET_W-1:0] offset_adjust;
	logic [SCFG_DATA_W-1:0] internal_settling_adjust;
	logic [SCFG_PATTERN_W-1:0] test_pattern;

	scfg_reg #(
		.W(SCFG_DATA_W),
		.RST(SCFG_RST_GENERAL_CONTROL)
	) u_general_control (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.clear(regs_clear),
		.we(we_control),
		.d(frame_data),
		.q(general_control)
	);

	scfg_reg #(
		.W(SCFG_GAIN_W),
		.RST(SCFG_RST_ANALOG_GAIN_ADJUST)
	) u_analog_gain_adjust (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.clear(regs_clear),
		.we(we_gain),
		.d(frame_data[SCFG_GAIN_W-1:0]),
		.q(analog_gain_adjust)
	);

	scfg_reg #(
		.W(SCFG_OFFSET_W),
		.RST(SCFG_RST_OFFSET_ADJUST)
	) u_offset_adjust (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.clear(regs_clear),
		.we(we_offset),
		.d(frame_data[SCFG_OFFSET_W-1:0]),
		.q(offset_adjust)
	);

	scfg_reg #(
		.W(SCFG_DATA_W),
		.RST(SCFG_RST_INTERNAL_SETTLING_ADJUST)
	) u_internal_settling_adjust (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.clear(regs_clear),
		.we(we_settling),
		.d(frame_data),
		.q(internal_settling_adjust)
	);

	scfg_reg #(
		.W(SCFG_PATTERN_W),
		.RST(SCFG_RST_TEST_PATTERN)
	) u_test_pattern (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.clear(regs_clear),
		.we(we_pattern),
		.d(frame_data[SCFG_PATTERN_W-1:0]),
		.q(test_pattern)
	);

	// field outputs are bits of the register flops themselves
	assign standby_field = general_control[SCFG_CTRL_STANDBY_BIT];
	assign track_hold_transparent = general_control[SCFG_CTRL_TRANSPARENT_BIT];
	assign test_enable = general_control[SCFG_CTRL_TEST_BIT];
	assign gain_code = analog_gain_adjust;
	assign offset_code = offset_adjust;
	assign dc_trim = internal_settling_adjust[SCFG_SET_DC_LSB +: SCFG_SET_DC_W];
	assign settling_trim = internal_settling_adjust[SCFG_SET_TRIM_LSB +: SCFG_SET_TRIM_W];
	assign duty_cycle = internal_settling_adjust[SCFG_SET_DUTY_LSB +: SCFG_SET_DUTY_W];
	assign test_pattern_word = test_pattern;

	// output data path
	logic [SCFG_PATTERN_W-1:0] next_data_out;
	logic [SCFG_PATTERN_W-1:0] next_data_out_n;

	// standby freezes the outputs but leaves every register as it is; the test
	// pattern still wins so the output pins can be checked while in standby
	always_comb begin
		next_data_out = data_out;
		next_data_out_n = data_out_n;
		if (test_enable) begin
			next_data_out = test_pattern;
			next_data_out_n = ~test_pattern;
		end else if (!standby_field) begin
			next_data_out = conv_data;
			next_data_out_n = ~conv_data;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			data_out <= '0;
			data_out_n <= '1;
		end else begin
			data_out <= next_data_out;
			data_out_n <= next_data_out_n;
		end
	end

	// status flops: write_done pulses for every completed frame, even one to an
	// unused address, so a controller can count its frames
	logic next_port_enabled;
	logic next_write_done;

	always_comb begin
		next_port_enabled = smode_s;
		next_write_done = frame_load;
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			port_enabled <= 1'b0;
			write_done <= 1'b0;
		end else begin
			port_enabled <= next_port_enabled;
			write_done <= next_write_done;
		end
	end
endmodule : scfg_port

/* File: verification/scfg_port_properties.sv */
// Purpose: port-level properties of the serial configuration port
// Assumes: bound to scfg_port, single sys_clk domain
// Notes: a gain, control or pattern change while enabled must coincide with the write_done pulse
`timescale 1ns/1ps
module scfg_port_checker
	import scfg_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [SCFG_PATTERN_W-1:0] conv_data,
	input wire logic standby_field,
	input wire logic track_hold_transparent,
	input wire logic test_enable,
	input wire logic [SCFG_GAIN_W-1:0] gain_code,
	input wire logic [SCFG_PATTERN_W-1:0] test_pattern_word,
	input wire logic [SCFG_PATTERN_W-1:0] data_out,
	input wire logic [SCFG_PATTERN_W-1:0] data_out_n,
	input wire logic port_enabled,
	input wire logic write_done
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	chk_out_compl: assert property (data_out_n == ~data_out)
		else $error("inverted outputs not the complement");
	chk_test_path: assert property (test_enable && !standby_field |=>
		data_out == $past(test_pattern_word)) else $error("test pattern not driven");
	chk_conv_path: assert property (!test_enable && !standby_field |=>
		data_out == $past(conv_data)) else $error("converter data not passed");
	chk_disabled_defaults: assert property (!port_enabled [*3] |->
		gain_code == 8'h80 && test_pattern_word == 12'h000 && !standby_field)
		else $error("defaults not held while disabled");
	chk_disabled_nowrite: assert property (!port_enabled [*3] |-> !write_done)
		else $error("write completed while disabled");
	chk_done_pulse: assert property (write_done |=> !write_done)
		else $error("write_done longer than one cycle");
	chk_gain_cause: assert property ($changed(gain_code) && port_enabled |->
		write_done) else $error("gain changed without a write");
	chk_ctrl_cause: assert property ($changed({standby_field, test_enable,
		track_hold_transparent, test_pattern_word}) && port_enabled |-> write_done)
		else $error("control changed without a write");
endmodule : scfg_port_checker

/* File: verification/scfg_ctrl_model.sv */
// Purpose: behavioural configuration controller driving the serial pins
// Assumes: sclk period 80 ns, stands low outside frames
// Notes: released sdata flips so a stale level is never mistaken for data
`timescale 1ns/1ps
module scfg_ctrl_model (
	output logic sclk,
	output logic sldn,
	output logic sdata
);
	initial begin
		sclk = 1'b0;
		sldn = 1'b1;
		sdata = 1'b0;
	end
	task automatic rise(input logic le, input logic bit_v);
		sldn = le;
		sdata = bit_v;
		#40 sclk = 1'b1;
		#40 sclk = 1'b0;
	endtask : rise
	// nlow other than 20 makes an aborted or overlong frame on purpose
	task automatic send(input logic [2:0] a, input logic [15:0] d, input int nlow, input logic arm);
		logic [18:0] frame;
		frame = {a, d};
		if (arm) rise(1'b1, ~sdata);
		for (int i = 0; i < nlow; i++) rise(1'b0, (i < 19) ? frame[18 - i] : ~sdata);
		rise(1'b1, ~sdata);
		sdata = ~sdata;
	endtask : send
endmodule : scfg_ctrl_model

/* File: verification/testbench.sv */
// Purpose: self-checking bench of the serial configuration port
// Assumes: expectations derived from the register table and field layout
// Notes: each frame is followed by a settle time for the pin synchroniser
`timescale 1ns/1ps
module testbench;
	import scfg_pkg::*;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic smode = 1'b0;
	logic [11:0] conv_data = 12'h000;
	logic sclk;
	logic sldn;
	logic sdata;
	logic standby_field;
	logic track_hold_transparent;
	logic test_enable;
	logic [7:0] gain_code;
	logic [7:0] offset_code;
	logic [4:0] dc_trim;
	logic [1:0] settling_trim;
	logic [2:0] duty_cycle;
	logic [11:0] test_pattern_word;
	logic [11:0] data_out;
	logic [11:0] data_out_n;
	logic port_enabled;
	logic write_done;
	int error_cnt = 0;
	int compares = 0;
	int done_cnt = 0;
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (write_done === 1'b1) done_cnt <= done_cnt + 1;
	scfg_ctrl_model scfg_ctrl_model_inst (.sclk(sclk), .sldn(sldn), .sdata(sdata));
	scfg_port scfg_port_inst (.sys_clk(sys_clk), .nrst(nrst), .smode(smode), .sclk(sclk),
		.sldn(sldn), .sdata(sdata), .conv_data(conv_data), .standby_field(standby_field),
		.track_hold_transparent(track_hold_transparent), .test_enable(test_enable),
		.gain_code(gain_code), .offset_code(offset_code), .dc_trim(dc_trim),
		.settling_trim(settling_trim), .duty_cycle(duty_cycle),
		.test_pattern_word(test_pattern_word), .data_out(data_out), .data_out_n(data_out_n),
		.port_enabled(port_enabled), .write_done(write_done));
	task automatic end_sim;
		if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [2:0] a, input logic [15:0] d, input int nlow, input logic arm);
		scfg_ctrl_model_inst.send(a, d, nlow, arm);
		repeat (12) @(posedge sys_clk);
		#1;
	endtask : wr
	initial begin
		#300000;
		error_cnt++;
		end_sim();
	end
	initial begin
		repeat (8) @(posedge sys_clk);
		#1 nrst = 1'b1;
		smode = 1'b1;
		repeat (10) @(posedge sys_clk);
		#1;
		chk(16'(gain_code), 16'h0080);
		chk(16'(offset_code), 16'h0080);
		chk(16'({duty_cycle, settling_trim, dc_trim}), 16'h0010);
		chk(16'({standby_field, test_enable, track_hold_transparent}), 16'h0000);
		chk(16'(test_pattern_word), 16'h0000);
		wr(SCFG_ADDR_ANALOG_GAIN_ADJUST, 16'hFF5A, 20, 1'b1);
		chk(16'(gain_code), 16'h005A);
		wr(SCFG_ADDR_OFFSET_ADJUST, 16'h1234, 20, 1'b1);
		chk(16'(offset_code), 16'h0034);
		wr(SCFG_ADDR_INTERNAL_SETTLING_ADJUST, 16'hA5C3, 20, 1'b1);
		chk(16'({duty_cycle, settling_trim, dc_trim}), 16'h02A3);
		wr(SCFG_ADDR_TEST_PATTERN, 16'hFABC, 20, 1'b1);
		chk(16'(test_pattern_word), 16'h0ABC);
		conv_data = 12'h123;
		wr(SCFG_ADDR_GENERAL_CONTROL, 16'h8080, 20, 1'b1);
		wr(SCFG_ADDR_ANALOG_GAIN_ADJUST, 16'h0011, 20, 1'b0);
		chk(16'(gain_code), 16'h0011);
		chk(16'({track_hold_transparent, test_enable, standby_field}), 16'h0006);
		chk(16'(data_out), 16'h0ABC);
		chk(16'(data_out_n), 16'h0543);
		wr(SCFG_ADDR_GENERAL_CONTROL, 16'h0000, 20, 1'b1);
		chk(16'(data_out), 16'h0123);
		chk(16'({track_hold_transparent, test_enable}), 16'h0000);
		wr(SCFG_ADDR_GENERAL_CONTROL, 16'h0001, 20, 1'b1);
		chk(16'({standby_field, gain_code}), 16'h0111);
		conv_data = 12'h456;
		repeat (4) @(posedge sys_clk);
		#1;
		chk(16'(data_out), 16'h0123);
		wr(SCFG_ADDR_ANALOG_GAIN_ADJUST, 16'h00EE, 10, 1'b1);
		chk(16'(gain_code), 16'h0011);
		wr(SCFG_ADDR_ANALOG_GAIN_ADJUST, 16'h0077, 26, 1'b1);
		chk(16'(gain_code), 16'h0077);
		wr(3'h3, 16'hFFFF, 20, 1'b1);
		wr(3'h6, 16'hFFFF, 20, 1'b1);
		wr(3'h7, 16'hFFFF, 20, 1'b1);
		chk(16'({gain_code, offset_code}), 16'h7734);
		chk(16'({duty_cycle, settling_trim, dc_trim}), 16'h02A3);
		chk(16'(test_pattern_word), 16'h0ABC);
		chk(16'(done_cnt), 16'h000C);
		// leaving standby here; this block has no timing reset pin to pulse
		smode = 1'b0;
		wr(SCFG_ADDR_ANALOG_GAIN_ADJUST, 16'h0022, 20, 1'b1);
		chk(16'(gain_code), 16'h0080);
		chk(16'({standby_field, test_pattern_word}), 16'h0000);
		chk(16'(data_out), 16'h0456);
		chk(16'(port_enabled), 16'h0000);
		chk(16'(done_cnt), 16'h000C);
		smode = 1'b1;
		repeat (10) @(posedge sys_clk);
		#1;
		chk(16'(port_enabled), 16'h0001);
		wr(SCFG_ADDR_ANALOG_GAIN_ADJUST, 16'h0033, 20, 1'b1);
		chk(16'(gain_code), 16'h0033);
		end_sim();
	end
endmodule : testbench
bind scfg_port scfg_port_checker scfg_port_checker_inst (.sys_clk, .nrst, .conv_data,
	.standby_field, .track_hold_transparent, .test_enable, .gain_code, .test_pattern_word,
	.data_out, .data_out_n, .port_enabled, .write_done);
